/* fcs_consts.svh */
// constants of the flash command state machine: codes, patterns and timing
`ifndef FCS_CONSTS_SVH
`define FCS_CONSTS_SVH

// ----------------------------------------------------------------------
// command codes on the data bus
// ----------------------------------------------------------------------
`define FCS_CODE_RESET      8'hf0
`define FCS_CODE_UNLOCK1    8'haa
`define FCS_CODE_UNLOCK2    8'h55
`define FCS_CODE_PROGRAM    8'ha0
`define FCS_CODE_SETUP      8'h80
`define FCS_CODE_CHIP       8'h10
`define FCS_CODE_SECTOR     8'h30
`define FCS_CODE_SUSPEND    8'hb0
`define FCS_CODE_RESUME     8'h30

// ----------------------------------------------------------------------
// address patterns, checked on address bits 11..0 only
// ----------------------------------------------------------------------
`define FCS_ADDR_PAT1       12'h555
`define FCS_ADDR_PAT2       12'h2aa

// ----------------------------------------------------------------------
// timing: times in ns, clock period 25 ns at 40 MHz
// ----------------------------------------------------------------------
`define FCS_CLK_NS          25
`define FCS_PROG_PULSE_NS   10000
`define FCS_ERASE_PULSE_NS  10000000
`define FCS_SUSPEND_MAX_NS  20000
`define FCS_SECT_TMO_NS     50000
// least times round up, the longest time rounds down
`define FCS_PROG_PULSE_CYC  ((`FCS_PROG_PULSE_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_SUSPEND_CYC     (`FCS_SUSPEND_MAX_NS / `FCS_CLK_NS)
`define FCS_SECT_TMO_CYC    ((`FCS_SECT_TMO_NS + `FCS_CLK_NS - 1) / `FCS_CLK_NS)
`define FCS_ERASE_PULSE_CYC (`FCS_ERASE_PULSE_NS / `FCS_CLK_NS)

// ----------------------------------------------------------------------
// pulse attempt limits before the timeout flag is raised
// ----------------------------------------------------------------------
`define FCS_PROG_MAX_TRIES  10'd25
`define FCS_ERASE_MAX_TRIES 10'd1000

`endif

/* fcs_pkg.sv */
// types of the flash command state machine
package fcs_pkg;

    typedef enum logic [3:0] {
        FCS_READ     = 4'b0000,
        FCS_UNL1     = 4'b0001,
        FCS_UNL2     = 4'b0010,
        FCS_PSETUP   = 4'b0011,
        FCS_ESETUP   = 4'b0100,
        FCS_EUNL1    = 4'b0101,
        FCS_EUNL2    = 4'b0110,
        FCS_SECT_TMO = 4'b0111,
        FCS_PREPROG  = 4'b1000,
        FCS_ERASE    = 4'b1001,
        FCS_PROG     = 4'b1010,
        FCS_SUSP_WT  = 4'b1011,
        FCS_SUSP     = 4'b1100,
        FCS_FAIL     = 4'b1101
    } fcs_state_t;

    typedef struct packed {
        fcs_state_t  st;
        fcs_state_t  sav;
        logic        susp;
        logic        chip;
        logic        fprog;
        logic        tmo;
        logic        tog;
        logic        stog;
        logic        pulse;
        logic [18:0] cnt;
        logic [9:0]  tries;
        logic [18:0] pa;
        logic [7:0]  pd;
        logic [10:0] sect;
        logic [7:0]  rd_data;
        logic        rd_valid;
        logic        drv_prog;
        logic        drv_zero;
        logic        drv_erase;
        logic        drv_verify;
    } fcs_regs_t;

endpackage

/* fcs_flash_cmd.sv */
// command state machine of the embedded flash array
`timescale 1ns/10ps
`include "fcs_consts.svh"

module fcs_flash_cmd #(
    parameter int ERASE_PULSE_CYC = `FCS_ERASE_PULSE_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    input  wire logic [18:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic [7:0]  arr_rdata,
    input  wire logic        arr_verify_ok,
    output logic      [7:0]  rd_data_q,
    output logic             rd_valid_q,
    output logic      [18:0] arr_addr_q,
    output logic      [7:0]  arr_wdata_q,
    output logic      [10:0] arr_sect_q,
    output logic             arr_prog_q,
    output logic             arr_zero_q,
    output logic             arr_erase_q,
    output logic             arr_verify_q,
    output logic             erase_suspended_q,
    output logic             timeout_flag_bit_q
);

    // ------------------------------------------------------------------
    // sector decode from address bits 18..13
    // ------------------------------------------------------------------
    function automatic logic [10:0] sect_bit(input logic [18:0] a);
        logic [3:0] idx;
        idx = 4'h0;
        if (a[18:16] != 3'h0) begin
            idx = 4'h3 + {1'b0, a[18:16]};
        end else if (a[15]) begin
            idx = 4'h3;
        end else if (a[14]) begin
            idx = 4'h1 + {3'h0, a[13]};
        end
        return 11'h001 << idx;
    endfunction

    fcs_pkg::fcs_regs_t q;
    fcs_pkg::fcs_regs_t d;

    logic             a_pat1;
    logic             a_pat2;
    logic             hit;
    logic             prog_busy;
    logic             erase_busy;
    logic             run;
    fcs_pkg::fcs_state_t idle_st;
    logic [18:0]      pulse_len;
    logic [9:0]       try_lim;

    // ------------------------------------------------------------------
    // status decode helpers
    // ------------------------------------------------------------------
    assign a_pat1     = (cpu_addr[11:0] == `FCS_ADDR_PAT1);
    assign a_pat2     = (cpu_addr[11:0] == `FCS_ADDR_PAT2);
    assign hit        = |(q.sect & sect_bit(cpu_addr));
    assign prog_busy  = (q.st == fcs_pkg::FCS_PROG) || (q.st == fcs_pkg::FCS_FAIL && q.fprog);
    assign erase_busy = (q.st == fcs_pkg::FCS_SECT_TMO) || (q.st == fcs_pkg::FCS_PREPROG)
                     || (q.st == fcs_pkg::FCS_ERASE) || (q.st == fcs_pkg::FCS_SUSP_WT)
                     || (q.st == fcs_pkg::FCS_FAIL && !q.fprog);
    // a broken or aborted sequence falls back to the mode it came from
    assign idle_st    = q.susp ? fcs_pkg::FCS_SUSP : fcs_pkg::FCS_READ;
    assign pulse_len  = (q.st == fcs_pkg::FCS_ERASE) ? 19'(ERASE_PULSE_CYC)
                                                      : 19'(`FCS_PROG_PULSE_CYC);
    assign try_lim    = (q.st == fcs_pkg::FCS_ERASE) ? `FCS_ERASE_MAX_TRIES
                                                      : `FCS_PROG_MAX_TRIES;

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        d          = q;
        run        = 1'b0;
        d.rd_valid = 1'b0;

        // read path: status while busy or on a selected sector while suspended, else array data
        if (cpu_rd) begin
            d.rd_valid = 1'b1;
            if (prog_busy) begin
                d.rd_data = {~q.pd[7], q.tog, q.tmo, 2'b00, q.stog, 2'b00};
                d.tog     = ~q.tog;
            end else if (erase_busy) begin
                d.rd_data = {1'b0, q.tog, q.tmo, 1'b0, (q.st != fcs_pkg::FCS_SECT_TMO),
                             q.stog, 2'b00};
                d.tog     = ~q.tog;
                if (hit) begin
                    d.stog = ~q.stog;
                end
            end else if (q.susp && hit) begin
                d.rd_data = {1'b1, q.tog, 3'b000, q.stog, 2'b00};
                d.stog    = ~q.stog;
            end else begin
                d.rd_data = arr_rdata;
            end
        end

        // command decode per state
        case (q.st)
            fcs_pkg::FCS_READ, fcs_pkg::FCS_SUSP: begin
                if (cpu_wr) begin
                    if (cpu_wdata == `FCS_CODE_UNLOCK1 && a_pat1) begin
                        d.st = fcs_pkg::FCS_UNL1;
                    end else if (q.susp && cpu_wdata == `FCS_CODE_RESUME) begin
                        d.st    = q.sav;
                        d.susp  = 1'b0;
                        d.pulse = 1'b1;
                        d.cnt   = (q.sav == fcs_pkg::FCS_ERASE) ? 19'(ERASE_PULSE_CYC)
                                                                : 19'(`FCS_PROG_PULSE_CYC);
                    end
                end
            end
            fcs_pkg::FCS_UNL1: begin
                if (cpu_wr) begin
                    d.st = (cpu_wdata == `FCS_CODE_UNLOCK2 && a_pat2)
                         ? fcs_pkg::FCS_UNL2 : idle_st;
                end
            end
            fcs_pkg::FCS_UNL2: begin
                if (cpu_wr) begin
                    if (a_pat1 && cpu_wdata == `FCS_CODE_PROGRAM) begin
                        d.st = fcs_pkg::FCS_PSETUP;
                    end else if (a_pat1 && cpu_wdata == `FCS_CODE_SETUP && !q.susp) begin
                        d.st = fcs_pkg::FCS_ESETUP;
                    end else begin
                        d.st = idle_st;
                    end
                end
            end
            fcs_pkg::FCS_PSETUP: begin
                if (cpu_wr) begin
                    if (cpu_wdata == `FCS_CODE_RESET) begin
                        d.st = idle_st;
                    end else begin
                        // cells only move toward 0, so merge with the stored byte
                        d.pa    = cpu_addr;
                        d.pd    = cpu_wdata & arr_rdata;
                        d.st    = fcs_pkg::FCS_PROG;
                        d.pulse = 1'b1;
                        d.cnt   = 19'(`FCS_PROG_PULSE_CYC);
                        d.tries = 10'h000;
                        d.tmo   = 1'b0;
                        d.fprog = 1'b1;
                    end
                end
            end
            fcs_pkg::FCS_ESETUP: begin
                if (cpu_wr) begin
                    d.st = (cpu_wdata == `FCS_CODE_UNLOCK1 && a_pat1)
                         ? fcs_pkg::FCS_EUNL1 : fcs_pkg::FCS_READ;
                end
            end
            fcs_pkg::FCS_EUNL1: begin
                if (cpu_wr) begin
                    d.st = (cpu_wdata == `FCS_CODE_UNLOCK2 && a_pat2)
                         ? fcs_pkg::FCS_EUNL2 : fcs_pkg::FCS_READ;
                end
            end
            fcs_pkg::FCS_EUNL2: begin
                if (cpu_wr) begin
                    d.tries = 10'h000;
                    d.tmo   = 1'b0;
                    d.fprog = 1'b0;
                    if (a_pat1 && cpu_wdata == `FCS_CODE_CHIP) begin
                        d.st    = fcs_pkg::FCS_PREPROG;
                        d.chip  = 1'b1;
                        d.sect  = 11'h7ff;
                        d.pulse = 1'b1;
                        d.cnt   = 19'(`FCS_PROG_PULSE_CYC);
                    end else if (cpu_wdata == `FCS_CODE_SECTOR) begin
                        d.st   = fcs_pkg::FCS_SECT_TMO;
                        d.chip = 1'b0;
                        d.sect = sect_bit(cpu_addr);
                        d.cnt  = 19'(`FCS_SECT_TMO_CYC);
                    end else begin
                        d.st = fcs_pkg::FCS_READ;
                    end
                end
            end
            fcs_pkg::FCS_SECT_TMO: begin
                // further sector codes extend the selection and restart the window
                if (cpu_wr && cpu_wdata == `FCS_CODE_SECTOR) begin
                    d.sect = q.sect | sect_bit(cpu_addr);
                    d.cnt  = 19'(`FCS_SECT_TMO_CYC);
                end else if (cpu_wr && cpu_wdata == `FCS_CODE_SUSPEND) begin
                    d.st   = fcs_pkg::FCS_SUSP;
                    d.susp = 1'b1;
                    d.sav  = fcs_pkg::FCS_PREPROG;
                end else if (cpu_wr && cpu_wdata == `FCS_CODE_RESET) begin
                    d.st   = fcs_pkg::FCS_READ;
                    d.sect = 11'h000;
                end else if (q.cnt == 19'h00000) begin
                    d.st    = fcs_pkg::FCS_PREPROG;
                    d.pulse = 1'b1;
                    d.cnt   = 19'(`FCS_PROG_PULSE_CYC);
                end else begin
                    d.cnt = q.cnt - 19'h00001;
                end
            end
            fcs_pkg::FCS_PREPROG, fcs_pkg::FCS_ERASE: begin
                if (cpu_wr && cpu_wdata == `FCS_CODE_SUSPEND && !q.chip) begin
                    d.st  = fcs_pkg::FCS_SUSP_WT;
                    d.sav = q.st;
                    d.cnt = 19'(`FCS_SUSPEND_CYC - 1);
                end else begin
                    run = 1'b1;
                end
            end
            fcs_pkg::FCS_PROG: begin
                run = 1'b1;
            end
            fcs_pkg::FCS_SUSP_WT: begin
                if (q.cnt == 19'h00000) begin
                    d.st   = fcs_pkg::FCS_SUSP;
                    d.susp = 1'b1;
                end else begin
                    d.cnt = q.cnt - 19'h00001;
                end
            end
            fcs_pkg::FCS_FAIL: begin
                if (cpu_wr && cpu_wdata == `FCS_CODE_RESET) begin
                    d.st  = idle_st;
                    d.tmo = 1'b0;
                    d.pa  = 19'h00000;
                    if (!q.susp) begin
                        d.sect = 11'h000;
                    end
                end
            end
            default: begin
                d.st = fcs_pkg::FCS_READ;
            end
        endcase

        // self-timed pulse, verify and retry loop
        if (run) begin
            if (q.pulse) begin
                if (q.cnt == 19'h00000) begin
                    d.pulse = 1'b0;
                end else begin
                    d.cnt = q.cnt - 19'h00001;
                end
            end else if (arr_verify_ok) begin
                if (q.st == fcs_pkg::FCS_PROG) begin
                    d.st = idle_st;
                    d.pa = 19'h00000;
                end else if (q.st == fcs_pkg::FCS_PREPROG) begin
                    d.st    = fcs_pkg::FCS_ERASE;
                    d.tries = 10'h000;
                    d.pulse = 1'b1;
                    d.cnt   = 19'(ERASE_PULSE_CYC);
                end else begin
                    d.st   = fcs_pkg::FCS_READ;
                    d.sect = 11'h000;
                    d.chip = 1'b0;
                end
            end else if (q.tries == try_lim) begin
                d.st  = fcs_pkg::FCS_FAIL;
                d.tmo = 1'b1;
            end else begin
                d.tries = q.tries + 10'h001;
                d.pulse = 1'b1;
                d.cnt   = pulse_len;
            end
        end

        // array strobes registered from the next state
        d.drv_prog   = (d.st == fcs_pkg::FCS_PROG) && d.pulse;
        d.drv_zero   = (d.st == fcs_pkg::FCS_PREPROG) && d.pulse;
        d.drv_erase  = (d.st == fcs_pkg::FCS_ERASE) && d.pulse;
        d.drv_verify = ((d.st == fcs_pkg::FCS_PROG) || (d.st == fcs_pkg::FCS_PREPROG)
                     || (d.st == fcs_pkg::FCS_ERASE)) && !d.pulse;
    end

    // ------------------------------------------------------------------
    // state register; reset aborts any pulse in the same edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // outputs straight from the state register
    assign rd_data_q          = q.rd_data;
    assign rd_valid_q         = q.rd_valid;
    assign arr_addr_q         = q.pa;
    assign arr_wdata_q        = q.pd;
    assign arr_sect_q         = q.sect;
    assign arr_prog_q         = q.drv_prog;
    assign arr_zero_q         = q.drv_zero;
    assign arr_erase_q        = q.drv_erase;
    assign arr_verify_q       = q.drv_verify;
    assign erase_suspended_q  = q.susp;
    assign timeout_flag_bit_q = q.tmo;

endmodule // fcs_flash_cmd

/* fcs_flash_cmd_assertions.sv */
// concurrent checks on the ports of the flash command state machine
`timescale 1ns/10ps
module fcs_flash_cmd_assertions (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        cpu_wr,
    input wire logic        cpu_rd,
    input wire logic [18:0] cpu_addr,
    input wire logic [7:0]  cpu_wdata,
    input wire logic [7:0]  arr_rdata,
    input wire logic        arr_verify_ok,
    input wire logic [7:0]  rd_data_q,
    input wire logic        rd_valid_q,
    input wire logic [18:0] arr_addr_q,
    input wire logic [7:0]  arr_wdata_q,
    input wire logic [10:0] arr_sect_q,
    input wire logic        arr_prog_q,
    input wire logic        arr_zero_q,
    input wire logic        arr_erase_q,
    input wire logic        arr_verify_q,
    input wire logic        erase_suspended_q,
    input wire logic        timeout_flag_bit_q
);
    // --------
    // helpers
    // --------
    logic [9:0] plen_q;
    logic [9:0] plen_d;
    logic       idle;
    // program pulse length, cleared while the pulse is low
    always_comb plen_d = arr_prog_q ? plen_q + 10'h001 : 10'h000;
    always_ff @(posedge clk_sys) plen_q <= rst ? 10'h000 : plen_d;
    // no array activity and no failure pending
    assign idle = !(arr_prog_q || arr_zero_q || arr_erase_q || arr_verify_q
                    || timeout_flag_bit_q);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_unlock;
        cpu_wr && cpu_wdata == 8'haa && cpu_addr[11:0] == 12'h555 ##1
        cpu_wr && cpu_wdata == 8'h55 && cpu_addr[11:0] == 12'h2aa;
    endsequence
    sequence s_prog_cmd;
        idle ##0 s_unlock ##1
        cpu_wr && cpu_wdata == 8'ha0 && cpu_addr[11:0] == 12'h555 ##1
        cpu_wr && cpu_wdata != 8'hf0;
    endsequence
    sequence s_sect_cmd;
        idle && !erase_suspended_q ##0 s_unlock ##1
        cpu_wr && cpu_wdata == 8'h80 && cpu_addr[11:0] == 12'h555 ##1 s_unlock ##1
        cpu_wr && cpu_wdata == 8'h30;
    endsequence
    // --------
    // checks
    // --------
    a_read_answer: assert property (cpu_rd |=> rd_valid_q)
        else $error("read got no answer");
    a_prog_start: assert property (s_prog_cmd |=> arr_prog_q && arr_addr_q == $past(cpu_addr))
        else $error("program did not start");
    a_prog_merge: assert property ($rose(arr_prog_q) && $past(cpu_wr) |->
        arr_wdata_q == $past(cpu_wdata & arr_rdata)) else $error("program data not merged");
    a_prog_width: assert property ($fell(arr_prog_q) && !$past(rst) |->
        plen_q == 10'd401 && arr_verify_q)
        else $error("program pulse length or verify wrong");
    a_busy_deaf: assert property (arr_prog_q && cpu_wr |=> arr_prog_q || arr_verify_q)
        else $error("write disturbed programming");
    a_reset_code: assert property (timeout_flag_bit_q && cpu_wr && cpu_wdata == 8'hf0
        |=> !timeout_flag_bit_q) else $error("reset code did not clear failure");
    a_susp_now: assert property (s_sect_cmd ##1 cpu_wr && cpu_wdata == 8'hb0
        |-> ##[1:2] erase_suspended_q) else $error("suspend in window not immediate");
    a_resume_clr: assert property (erase_suspended_q && idle && cpu_wr &&
        cpu_wdata == 8'h30 && !$past(cpu_wr) |=> !erase_suspended_q) else $error("resume ignored");
endmodule // fcs_flash_cmd_assertions

bind fcs_flash_cmd fcs_flash_cmd_assertions fcs_flash_cmd_assertions_i (.*);

/* fcs_array_model.sv */
// behavioural cell array behind the flash command state machine
`timescale 1ns/10ps
module fcs_array_model (
    input wire logic        clk_sys,
    input wire logic [18:0] cpu_addr,
    input wire logic [18:0] arr_addr_q,
    input wire logic [7:0]  arr_wdata_q,
    input wire logic [10:0] arr_sect_q,
    input wire logic        arr_prog_q,
    input wire logic        arr_zero_q,
    input wire logic        arr_erase_q,
    input wire logic        verify_bad,
    output logic      [7:0] arr_rdata,
    output logic            arr_verify_ok
);
    // -----------
    // cell array
    // -----------
    logic [7:0] mem [0:524287];
    logic [2:0] lvl_q;
    int         s;
    initial for (int i = 0; i < 524288; i++) mem[i] = 8'hff;
    assign arr_rdata     = mem[cpu_addr];
    assign arr_verify_ok = !verify_bad; // fails only when a timeout is wanted
    // act on rising pulse levels; programming can only clear bits
    always @(posedge clk_sys) begin
        lvl_q <= {arr_prog_q, arr_zero_q, arr_erase_q};
        if (arr_prog_q && !lvl_q[2]) mem[arr_addr_q] = mem[arr_addr_q] & arr_wdata_q;
        if ((arr_zero_q && !lvl_q[1]) || (arr_erase_q && !lvl_q[0])) begin
            for (int i = 0; i < 524288; i++) begin
                s = (i >= 65536) ? 3 + i / 65536 : (i >= 32768) ? 3 :
                    (i >= 16384) ? 1 + (i / 8192) % 2 : 0;
                if (arr_sect_q[s]) mem[i] = arr_erase_q ? 8'hff : 8'h00;
            end
        end
    end
endmodule // fcs_array_model

/* fcs_flash_cmd_tb.sv */
// self-checking bench for the flash command state machine
`timescale 1ns/10ps
module fcs_flash_cmd_tb;
    localparam logic [26:0] UL1 = {19'h00555, 8'haa};
    localparam logic [26:0] UL2 = {19'h002aa, 8'h55};
    localparam logic [26:0] SET = {19'h00555, 8'h80};
    localparam logic [18:0] SA  = 19'h20123; // inside sector 5
    localparam logic [18:0] PA  = 19'h12345;
    logic        clk_sys, rst, cpu_wr, cpu_rd, arr_verify_ok, rd_valid_q, verify_bad;
    logic        arr_prog_q, arr_zero_q, arr_erase_q, arr_verify_q;
    logic        erase_suspended_q, timeout_flag_bit_q;
    logic [18:0] cpu_addr, arr_addr_q;
    logic [7:0]  cpu_wdata, arr_rdata, rd_data_q, arr_wdata_q, d, d2;
    logic [10:0] arr_sect_q;
    int          num_errors, checked;
    wire  [4:0]  flg = {timeout_flag_bit_q, erase_suspended_q, arr_erase_q, arr_zero_q,
                        arr_prog_q};
    fcs_flash_cmd #(.ERASE_PULSE_CYC(20)) fcs_flash_cmd_i (.*);
    fcs_array_model fcs_array_model_i (.*);
    // ------
    // tasks
    // ------
    task automatic chk(input logic [18:0] got, input logic [18:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t saw %h expected %h", $time, got, exp);
        end
    endtask
    // writes back to back, then one idle edge so the strobe is never set twice at once
    task automatic cmd(input logic [26:0] w [$]);
        foreach (w[i]) begin
            {cpu_addr, cpu_wdata} <= w[i];
            cpu_wr                <= 1'b1;
            @(posedge clk_sys);
        end
        cpu_wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [18:0] a, output logic [7:0] v);
        cpu_rd   <= 1'b1;
        cpu_addr <= a;
        @(posedge clk_sys);
        cpu_rd <= 1'b0;
        @(posedge clk_sys);
        chk(19'(rd_valid_q), 19'h1);
        v = rd_data_q;
    endtask
    task automatic wait_flag(input int k, input logic v, input int lim);
        int n;
        n = 0;
        while (flg[k] !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        chk(19'(flg[k]), 19'(v));
    endtask
    task automatic prog(input logic [18:0] a, input logic [7:0] v);
        cmd('{UL1, UL2, {19'h00555, 8'ha0}, {a, v}});
    endtask
    // ----------
    // scenarios
    // ----------
    task automatic t_prog;
        fcs_array_model_i.mem[PA] = 8'h5a;
        cmd('{{19'h7f555, 8'haa}, {19'h3a2aa, 8'h55}, {19'h40555, 8'ha0}, {PA, 8'h0f}});
        chk(19'(arr_prog_q), 19'h1);
        chk(arr_addr_q, PA);
        chk(19'(arr_wdata_q), 19'h0a);
        cmd('{{19'h00000, 8'hf0}});
        rd(PA, d);
        rd(PA, d2);
        chk(19'(d[7]), 19'h1);
        chk(19'(d2[6] ^ d[6]), 19'h1);
        chk(19'(arr_prog_q), 19'h1);
        wait_flag(0, 1'b0, 500);
        repeat (3) @(posedge clk_sys);
        chk(arr_addr_q, 19'h0);
        rd(PA, d);
        chk(19'(d), 19'h0a);
    endtask
    // broken sequences, then a program that runs into its attempt limit
    task automatic t_fail;
        for (int i = 0; i < 2; i++) begin
            cmd('{UL1, UL2, {19'h00555, i ? 8'h77 : 8'hf0}, {19'h00400, 8'h00}});
            chk(19'(arr_prog_q), 19'h0);
        end
        verify_bad <= 1'b1;
        prog(19'h00777, 8'h00);
        wait_flag(4, 1'b1, 12000);
        rd(19'h00777, d);
        chk(19'(d[5]), 19'h1);
        verify_bad <= 1'b0;
        cmd('{{19'h7ffff, 8'hf0}});
        chk(19'(timeout_flag_bit_q), 19'h0);
        rd(19'h00777, d);
        chk(19'(d), 19'h00);
    endtask
    task automatic t_chip;
        cmd('{UL1, UL2, SET, UL1, UL2, {19'h00555, 8'h10}});
        wait_flag(1, 1'b1, 50);
        chk(19'(arr_sect_q), 19'h7ff);
        wait_flag(2, 1'b1, 30000);
        rd(PA, d);
        chk(19'(d[7]), 19'h0);
        wait_flag(2, 1'b0, 30000);
        repeat (4) @(posedge clk_sys);
        rd(PA, d);
        chk(19'(d), 19'hff);
    endtask
    // suspend in the sector window, program meanwhile, resume and finish
    task automatic t_sect;
        cmd('{UL1, UL2, SET, UL1, UL2, {SA, 8'h30}, {19'h00000, 8'hb0}});
        wait_flag(3, 1'b1, 4);
        rd(SA, d);
        chk(19'(d[7]), 19'h1);
        prog(19'h00200, 8'h3c);
        wait_flag(0, 1'b0, 500);
        repeat (3) @(posedge clk_sys);
        rd(19'h00200, d);
        chk(19'(d), 19'h3c);
        rd(SA, d);
        chk(19'(d[7]), 19'h1);
        cmd('{{19'h00000, 8'h30}});
        wait_flag(3, 1'b0, 4);
        wait_flag(1, 1'b1, 50);
        chk(19'(arr_sect_q), 19'h020);
        wait_flag(2, 1'b1, 30000);
        wait_flag(2, 1'b0, 30000);
        repeat (4) @(posedge clk_sys);
        rd(SA, d);
        chk(19'(d), 19'hff);
        cmd('{{19'h00000, 8'hb0}, {19'h00000, 8'h30}});
        repeat (3) @(posedge clk_sys);
        chk(19'(flg[3:1]), 19'h0);
    endtask
    // hardware reset in mid-program, then the program is issued again
    task automatic t_hwrst;
        prog(19'h00300, 8'h81);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        chk(19'(flg), 19'h0);
        chk(arr_addr_q, 19'h0);
        prog(19'h00300, 8'h81);
        wait_flag(0, 1'b0, 500);
        repeat (3) @(posedge clk_sys);
        rd(19'h00300, d);
        chk(19'(d), 19'h81);
    endtask
    // ----
    // run
    // ----
    task automatic end_sim;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // watchdog well beyond the slowest expected run
    initial begin
        repeat (90000) @(posedge clk_sys);
        num_errors++;
        end_sim;
    end
    initial begin
        rst        = 1'b1;
        cpu_wr     = 1'b0;
        cpu_rd     = 1'b0;
        cpu_addr   = 19'h00000;
        cpu_wdata  = 8'h00;
        verify_bad = 1'b0;
        num_errors = 0;
        checked    = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rd(PA, d);
        chk(19'(d), 19'hff);
        t_prog;
        t_fail;
        t_chip;
        t_sect;
        t_hwrst;
        end_sim;
    end
endmodule // fcs_flash_cmd_tb
